// file: hdl/remote_link_defines.svh
// constants of the remote I/O and remote register link
`ifndef REMOTE_LINK_DEFINES_SVH
`define REMOTE_LINK_DEFINES_SVH

// ======================================================================
// command and response word layout
`define STROBE_BIT      14
`define RESULT_BIT      15
`define DONE_BIT        14
`define CODE_W          14

// ======================================================================
// command codes of the parameters held here
`define RD_GROUP_ADDR   14'h0018
`define WR_GROUP_ADDR   14'h1018
`define RD_GROUP_MASK   14'h0019
`define WR_GROUP_MASK   14'h1019
`define RD_INIT_GROUP   14'h09D1
`define WR_INIT_GROUP   14'h19D1

// ======================================================================
// parameter values and ranges
`define NO_GROUP        32'hFFFF_FFFF
`define GROUP_ADDR_MAX  32'h0000_000F
`define INIT_GROUP_MAX  32'h0000_001F
`define MASK_MAX        32'h0000_FFFF
`define MASK_RESET      16'h0000
`define LOW_BYTE_ONLY   16'h00FF
`define ADDR_MIN_W      5

// ======================================================================
// remote input bit positions
`define IN_SEL_LSB      0
`define IN_SEL_MSB      2
`define IN_START        3
`define IN_HOME         4
`define IN_STOP         5
`define IN_FREE         6
`define IN_ALM_CLR      7
`define IN_DSEL_LSB     8
`define IN_DSEL_MSB     10
`define IN_SEQUENTIAL_START       11
`define IN_FW_JOG       12
`define IN_RV_JOG       13
`define IN_FORWARD_POSITION_MOVE       14
`define IN_REVERSE_POSITION_MOVE       15

`endif

// file: hdl/remote_link_pkg.sv
// types shared by the remote link modules
package remote_link_pkg;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h1,
      ST_EXEC = 3'h2,
      ST_DONE = 3'h4
   } cmd_state_t;

   typedef enum logic [1:0] {
      SEL_GROUP = 2'h0,
      SEL_INIT  = 2'h1,
      SEL_MASK  = 2'h2
   } param_sel_t;

   typedef struct packed {
      logic [31:0] group_addr;
      logic [31:0] init_group;
      logic [15:0] mask;
      logic [31:0] rd_data;
   } param_regs_t;

   typedef struct packed {
      cmd_state_t  st;
      logic        strobe_prev;
      logic [13:0] code;
      logic [31:0] data;
      logic        result;
      logic        done;
      logic [15:0] in_word;
      logic [15:0] out_word;
      logic        nv_loaded;
      logic        nv_wr;
   } link_state_t;

endpackage : remote_link_pkg

// file: hdl/param_store.sv
// group parameter store with registered read port
`timescale 1ns/1ps
`include "remote_link_defines.svh"

module param_store (
   input  wire logic                    i_clk_sys,
   input  wire logic                    i_nrst,
   input  wire logic                    i_wr_en,
   input  wire remote_link_pkg::param_sel_t i_wr_sel,
   input  wire logic [31:0]             i_wr_data,
   input  wire remote_link_pkg::param_sel_t i_rd_sel,
   input  wire logic                    i_nv_load,
   input  wire logic [31:0]             i_nv_value,
   input  wire logic [15:0]             i_nv_mask,
   output logic [31:0]                  o_rd_data,
   output logic [31:0]                  o_group_addr,
   output logic [15:0]                  o_group_mask
);
   import remote_link_pkg::*;

   param_regs_t r_q;
   param_regs_t r_d;
   logic        nv_ok;

   // ======================================================================
   // next state
   always_comb begin
      r_d   = r_q;
      nv_ok = (i_nv_value == `NO_GROUP) || (i_nv_value <= `INIT_GROUP_MAX);
      if (i_nv_load) begin
         // saved setting applied once after power-up
         r_d.init_group = nv_ok ? i_nv_value : `NO_GROUP;
         r_d.group_addr = nv_ok ? i_nv_value : `NO_GROUP;
         r_d.mask       = i_nv_mask;
      end else if (i_wr_en) begin
         case (i_wr_sel)
            SEL_GROUP: r_d.group_addr = i_wr_data;
            SEL_INIT:  r_d.init_group = i_wr_data;
            SEL_MASK:  r_d.mask       = i_wr_data[15:0];
            default:   r_d.group_addr = r_q.group_addr;
         endcase
      end
      case (i_rd_sel)
         SEL_GROUP: r_d.rd_data = r_q.group_addr;
         SEL_INIT:  r_d.rd_data = r_q.init_group;
         SEL_MASK:  r_d.rd_data = {16'h0000, r_q.mask};
         default:   r_d.rd_data = 32'h0000_0000;
      endcase
   end

   // ======================================================================
   // registers; volatile copy resets to no group, then takes the saved value
   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         r_q.group_addr <= `NO_GROUP;
         r_q.init_group <= `NO_GROUP;
         r_q.mask       <= `MASK_RESET;
         r_q.rd_data    <= 32'h0000_0000;
      end else begin
         r_q <= r_d;
      end
   end

   assign o_rd_data    = r_q.rd_data;
   assign o_group_addr = r_q.group_addr;
   assign o_group_mask = r_q.mask;

endmodule : param_store

// file: hdl/remote_io_register_link.sv
// driver end of the cyclic remote I/O and remote register link
// Summary of operation
// - 16-bit input word maps select, start, home, stop, free, clear, direct, jog, moves.
// - 8-bit mode keeps only the low byte of input and output words.
// - output word reports echoes, home end, ready, information_flag, alarm, busy, zones, motion.
// - command runs only on a zero-to-one strobe edge; steady strobe does nothing.
// - response carries result in bit 15, completion in bit 14, echoed code below.
// - completion flag rises once the requested command has finished.
// - each remote input bit is chosen separately as group-delivered or individual.
// - only remote inputs use the group; commands are always individually addressed.
// - child with a parent address set accepts inputs sent to that parent address.
// - parent needs no setting; its own address serves as the group address.
// - volatile group address: minus one is no group, 0 to 15 parent; starts at the saved initial group address.
// - power loss returns the volatile group address to the saved initial group address.
// - saved initial group address, minus one or 0 to 31, is applied at power-up.
`timescale 1ns/1ps
`include "remote_link_defines.svh"

module remote_io_register_link #(
   parameter int ADDR_W = 5
) (
   input  wire logic              i_clk_sys,
   input  wire logic              i_nrst,
   input  wire logic              i_mode_8bit,
   input  wire logic [ADDR_W-1:0] i_own_address,
   input  wire logic              i_frame_valid,
   input  wire logic [ADDR_W-1:0] i_frame_address,
   input  wire logic [15:0]       i_net_input_word,
   input  wire logic [15:0]       i_command_word,
   input  wire logic [31:0]       i_command_data,
   input  wire logic [31:0]       i_saved_parent_address,
   input  wire logic [15:0]       i_saved_group_mask,
   input  wire logic              i_home_end,
   input  wire logic              i_ready,
   input  wire logic              i_information_flag,
   input  wire logic              i_alarm_flag,
   input  wire logic              i_busy_flag,
   input  wire logic [2:0]        i_zone_out,
   input  wire logic              i_timing_pulse,
   input  wire logic              i_moving,
   input  wire logic              i_in_position,
   input  wire logic              i_torque_limited,
   output logic [15:0]            o_net_input_word,
   output logic [15:0]            o_net_output_word,
   output logic [15:0]            o_response_word,
   output logic [31:0]            o_response_data,
   output logic [2:0]             o_op_select,
   output logic                   o_start,
   output logic                   o_go_home,
   output logic                   o_stop,
   output logic                   o_free,
   output logic                   o_alarm_clear,
   output logic [2:0]             o_direct_select,
   output logic                   o_sequential_start,
   output logic                   o_forward_jog,
   output logic                   o_reverse_jog,
   output logic                   o_forward_position_move,
   output logic                   o_reverse_position_move,
   output logic                   o_nv_write,
   output logic [31:0]            o_nv_data
);
   import remote_link_pkg::*;

   if (ADDR_W < `ADDR_MIN_W) begin : g_addr_chk
      $error("ADDR_W too narrow for parent addresses up to 31");
   end

   link_state_t s_q;
   link_state_t s_d;

   logic        strobe_now;
   logic        strobe_rise;
   logic [31:0] group_addr;
   logic [15:0] group_mask;
   logic [31:0] rd_data;
   logic        group_on;
   logic [15:0] eff_mask;
   logic        own_hit;
   logic        grp_hit;
   logic [15:0] width_mask;
   logic        wr_en;
   param_sel_t  wr_sel;
   param_sel_t  rd_sel;
   logic        code_known;
   logic        range_ok;
   logic        is_write;

   // ======================================================================
   // strobe edge; bit 15 of the command word is ignored
   assign strobe_now  = i_command_word[`STROBE_BIT];
   assign strobe_rise = strobe_now && !s_q.strobe_prev;

   // ======================================================================
   // group matching
   assign width_mask = i_mode_8bit ? `LOW_BYTE_ONLY : 16'hFFFF;
   assign group_on   = (group_addr != `NO_GROUP);
   // per-bit choice only counts while a group is set
   assign eff_mask   = group_on ? group_mask : `MASK_RESET;
   // parent matches on own address alone, no setting needed
   assign own_hit    = i_frame_valid && (i_frame_address == i_own_address);
   // child takes slots sent to its parent address
   assign grp_hit    = i_frame_valid && group_on &&
                       ({{(32-ADDR_W){1'b0}}, i_frame_address} == group_addr);

   // ======================================================================
   // command decode; the command port only ever addresses this driver
   always_comb begin
      rd_sel     = SEL_GROUP;
      code_known = 1'b1;
      is_write   = 1'b0;
      range_ok   = 1'b1;
      case (s_q.code)
         `RD_GROUP_ADDR: rd_sel = SEL_GROUP;
         `RD_INIT_GROUP: rd_sel = SEL_INIT;
         `RD_GROUP_MASK: rd_sel = SEL_MASK;
         `WR_GROUP_ADDR: begin
            rd_sel   = SEL_GROUP;
            is_write = 1'b1;
            range_ok = (s_q.data == `NO_GROUP) || (s_q.data <= `GROUP_ADDR_MAX);
         end
         `WR_INIT_GROUP: begin
            rd_sel   = SEL_INIT;
            is_write = 1'b1;
            range_ok = (s_q.data == `NO_GROUP) || (s_q.data <= `INIT_GROUP_MAX);
         end
         `WR_GROUP_MASK: begin
            rd_sel   = SEL_MASK;
            is_write = 1'b1;
            range_ok = (s_q.data <= `MASK_MAX);
         end
         default: code_known = 1'b0;
      endcase
   end

   assign wr_sel = rd_sel;
   assign wr_en  = (s_q.st == ST_EXEC) && is_write && code_known && range_ok;

   // ======================================================================
   // next state
   always_comb begin
      s_d             = s_q;
      s_d.strobe_prev = strobe_now;
      s_d.nv_loaded   = 1'b1;
      s_d.nv_wr       = 1'b0;

      // remote inputs: individual bits from own slot, group bits from parent slot
      if (own_hit) begin
         s_d.in_word = (s_d.in_word & eff_mask) | (i_net_input_word & ~eff_mask);
      end
      if (grp_hit) begin
         s_d.in_word = (s_d.in_word & ~eff_mask) | (i_net_input_word & eff_mask);
      end
      s_d.in_word = s_d.in_word & width_mask;

      // remote outputs
      s_d.out_word = {i_torque_limited, i_in_position, i_moving, i_timing_pulse,
                      i_zone_out, i_busy_flag,
                      i_alarm_flag, i_information_flag, i_ready, i_home_end,
                      s_q.in_word[`IN_START], s_q.in_word[`IN_SEL_MSB:`IN_SEL_LSB]}
                     & width_mask;

      case (s_q.st)
         ST_IDLE: begin
            if (strobe_rise) begin
               s_d.code = i_command_word[`CODE_W-1:0];
               s_d.data = i_command_data;
               s_d.st   = ST_EXEC;
            end
         end
         ST_EXEC: begin
            s_d.result = !(code_known && range_ok);
            s_d.nv_wr  = wr_en && (wr_sel == SEL_INIT);
            s_d.done   = 1'b1;
            s_d.st     = ST_DONE;
         end
         ST_DONE: begin
            if (!strobe_now) begin
               s_d.done = 1'b0;
               s_d.st   = ST_IDLE;
            end
         end
         default: begin
            s_d.st   = ST_IDLE;
            s_d.done = 1'b0;
         end
      endcase
   end

   // ======================================================================
   // state register
   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         s_q.st          <= ST_IDLE;
         s_q.strobe_prev <= 1'b0;
         s_q.code        <= 14'h0000;
         s_q.data        <= 32'h0000_0000;
         s_q.result      <= 1'b0;
         s_q.done        <= 1'b0;
         s_q.in_word     <= 16'h0000;
         s_q.out_word    <= 16'h0000;
         s_q.nv_loaded   <= 1'b0;
         s_q.nv_wr       <= 1'b0;
      end else begin
         s_q <= s_d;
      end
   end

   // ======================================================================
   // parameter store; saved values loaded on the first edge after release
   param_store u_store (
      .i_clk_sys    (i_clk_sys),
      .i_nrst       (i_nrst),
      .i_wr_en      (wr_en),
      .i_wr_sel     (wr_sel),
      .i_wr_data    (s_q.data),
      .i_rd_sel     (rd_sel),
      .i_nv_load    (!s_q.nv_loaded),
      .i_nv_value   (i_saved_parent_address),
      .i_nv_mask    (i_saved_group_mask),
      .o_rd_data    (rd_data),
      .o_group_addr (group_addr),
      .o_group_mask (group_mask)
   );

   // ======================================================================
   // outputs
   assign o_net_input_word        = s_q.in_word;
   assign o_net_output_word       = s_q.out_word;
   assign o_response_word         = {s_q.result, s_q.done, s_q.code};
   // read data is the value before a write in the same exchange
   assign o_response_data         = rd_data;
   assign o_nv_write              = s_q.nv_wr;
   assign o_nv_data               = s_q.data;
   assign o_op_select             = s_q.in_word[`IN_SEL_MSB:`IN_SEL_LSB];
   assign o_start                 = s_q.in_word[`IN_START];
   assign o_go_home               = s_q.in_word[`IN_HOME];
   assign o_stop                  = s_q.in_word[`IN_STOP];
   assign o_free                  = s_q.in_word[`IN_FREE];
   assign o_alarm_clear           = s_q.in_word[`IN_ALM_CLR];
   assign o_direct_select         = s_q.in_word[`IN_DSEL_MSB:`IN_DSEL_LSB];
   assign o_sequential_start      = s_q.in_word[`IN_SEQUENTIAL_START];
   assign o_forward_jog           = s_q.in_word[`IN_FW_JOG];
   assign o_reverse_jog           = s_q.in_word[`IN_RV_JOG];
   assign o_forward_position_move = s_q.in_word[`IN_FORWARD_POSITION_MOVE];
   assign o_reverse_position_move = s_q.in_word[`IN_REVERSE_POSITION_MOVE];

   // ======================================================================
   // checks
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_nrst);

   sequence rise_in_idle_s;
      s_q.st == ST_IDLE && strobe_now && !s_q.strobe_prev;
   endsequence

   sequence finish_s;
      !o_response_word[`DONE_BIT] ##1 !o_response_word[`DONE_BIT] ##1 o_response_word[`DONE_BIT];
   endsequence

   exec_on_rise_a: assert property (rise_in_idle_s |-> finish_s)
      else $error("command not completed two cycles after strobe rise");

   no_exec_steady_a: assert property (
      s_q.st == ST_IDLE && !(strobe_now && !s_q.strobe_prev) |=> s_q.st == ST_IDLE)
      else $error("command started without a strobe rise");

   done_hold_a: assert property (
      o_response_word[`DONE_BIT] && strobe_now |=> o_response_word[`DONE_BIT])
      else $error("completion dropped while strobe still high");

   done_clear_a: assert property (
      o_response_word[`DONE_BIT] && !strobe_now |=> !o_response_word[`DONE_BIT])
      else $error("completion not cleared after strobe fell");

   code_echo_a: assert property (
      rise_in_idle_s |-> ##2 o_response_word[`CODE_W-1:0] == $past(i_command_word[`CODE_W-1:0], 2))
      else $error("response does not echo the command code");

   bad_code_a: assert property (
      s_q.st == ST_EXEC && !code_known |=> o_response_word[`RESULT_BIT])
      else $error("unknown command not flagged abnormal");

   narrow_in_a: assert property (
      i_mode_8bit |=> o_net_input_word[15:8] == 8'h00)
      else $error("high input byte set in 8-bit mode");

   out_map_a: assert property (
      !i_mode_8bit |=> o_net_output_word[15:8] == {$past(i_torque_limited), $past(i_in_position),
         $past(i_moving), $past(i_timing_pulse), $past(i_zone_out), $past(i_busy_flag)})
      else $error("output word high byte mismatch");

   own_slot_a: assert property (
      own_hit && !grp_hit && !i_mode_8bit |=>
         (o_net_input_word & ~$past(eff_mask)) == ($past(i_net_input_word) & ~$past(eff_mask)))
      else $error("individual bits not taken from own slot");

   group_slot_a: assert property (
      grp_hit && !own_hit && !i_mode_8bit |=>
         (o_net_input_word & $past(eff_mask)) == ($past(i_net_input_word) & $past(eff_mask)))
      else $error("group bits not taken from parent slot");

   group_range_a: assert property (
      s_q.st == ST_EXEC && is_write && !range_ok |=> o_response_word[`RESULT_BIT] && $stable(group_addr))
      else $error("out of range write not refused");

   group_write_a: assert property (
      wr_en && wr_sel == SEL_GROUP |=> group_addr == $past(s_q.data))
      else $error("group address write did not land");

endmodule : remote_io_register_link

// file: bench/converter_model.sv
// converter-side model of the remote register handshake
`timescale 1ns/1ps

module converter_model (
   input  wire logic        i_clk_sys,
   input  wire logic [15:0] i_response_word,
   input  wire logic [31:0] i_response_data,
   output logic      [15:0] o_command_word,
   output logic      [31:0] o_command_data
);
   logic hung = 1'b0;

   initial begin
      o_command_word = 16'h0000;
      o_command_data = 32'h0000_0000;
   end

   // ======================================================================
   // one exchange; linger keeps the strobe high past completion, linger >= 1
   task automatic exchange(input logic [13:0] code, input logic [31:0] data, input logic b15,
                           input int linger, output logic [15:0] rsp, output logic [31:0] rdat,
                           output int lat);
      int n;
      lat = 0;
      @(posedge i_clk_sys);
      #1;
      o_command_word = {b15, 1'b1, code};
      o_command_data = data;
      for (n = 1; n <= 20 && lat == 0; n++) begin
         @(posedge i_clk_sys);
         #1;
         if (i_response_word[14] === 1'b1) lat = n;
      end
      if (lat == 0) hung = 1'b1;
      rdat = i_response_data;
      // data moves while the strobe stands: must not start a second run
      o_command_data = data ^ 32'h0000_0001;
      repeat (linger) begin
         @(posedge i_clk_sys);
         #1;
      end
      rsp = i_response_word;
      // released lines show the inverse, never the last value
      o_command_word = {~b15, 1'b0, ~code};
      o_command_data = ~data;
      for (n = 0; n < 20 && i_response_word[14] !== 1'b0; n++) begin
         @(posedge i_clk_sys);
         #1;
      end
      if (n == 20) hung = 1'b1;
   endtask : exchange
endmodule : converter_model

// file: bench/remote_io_register_link_tb.sv
// self-checking bench of the remote I/O and register link
`timescale 1ns/1ps
`include "remote_link_defines.svh"
`define CHK(what, exp, got) begin checked++; if ((got) !== (exp)) begin failures++; \
   $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got); end end

module remote_io_register_link_tb;
   import remote_link_pkg::*;
   logic        clk = 1'b0, nrst = 1'b0, mode8 = 1'b0, fv = 1'b0;
   logic [4:0]  own = 5'h05, faddr = 5'h00;
   logic [15:0] fword = 16'h0000, smask = 16'h0000, cmd_w, in_w, out_w, rsp_w;
   logic [31:0] spa = 32'hFFFF_FFFF, cmd_d, rsp_d, nv_d, nv_seen;
   logic [11:0] st = 12'h000;
   logic [2:0]  op_sel, dsel;
   logic        start, home, stop, free_o, aclr, sequential_start, fjog, rjog, fpos, rpos, nv_wr;
   int          failures = 0, checked = 0, nv_cnt = 0;

   always #2 clk = ~clk;

   remote_io_register_link #(.ADDR_W(5)) uut (
      .i_clk_sys(clk), .i_nrst(nrst), .i_mode_8bit(mode8), .i_own_address(own),
      .i_frame_valid(fv), .i_frame_address(faddr), .i_net_input_word(fword),
      .i_command_word(cmd_w), .i_command_data(cmd_d), .i_saved_parent_address(spa),
      .i_saved_group_mask(smask), .i_home_end(st[0]), .i_ready(st[1]), .i_information_flag(st[2]),
      .i_alarm_flag(st[3]), .i_busy_flag(st[4]), .i_zone_out(st[7:5]), .i_timing_pulse(st[8]),
      .i_moving(st[9]), .i_in_position(st[10]), .i_torque_limited(st[11]),
      .o_net_input_word(in_w), .o_net_output_word(out_w), .o_response_word(rsp_w),
      .o_response_data(rsp_d), .o_op_select(op_sel), .o_start(start), .o_go_home(home),
      .o_stop(stop), .o_free(free_o), .o_alarm_clear(aclr), .o_direct_select(dsel),
      .o_sequential_start(sequential_start), .o_forward_jog(fjog), .o_reverse_jog(rjog),
      .o_forward_position_move(fpos), .o_reverse_position_move(rpos),
      .o_nv_write(nv_wr), .o_nv_data(nv_d));

   converter_model cm (.i_clk_sys(clk), .i_response_word(rsp_w), .i_response_data(rsp_d),
      .o_command_word(cmd_w), .o_command_data(cmd_d));

   // pulse is one cycle wide, so count it mid-cycle where it is settled
   always @(negedge clk) begin
      if (nv_wr === 1'b1) begin
         nv_cnt++;
         nv_seen = nv_d;
      end
   end

   // ======================================================================
   // access tasks
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : tally_and_finish

   task automatic rst(input logic [31:0] pa, input logic [15:0] m);
      @(posedge clk);
      #1 nrst = 1'b0;
      spa = pa;
      smask = m;
      repeat (5) @(posedge clk);
      #1 nrst = 1'b1;
      repeat (2) @(posedge clk);
   endtask : rst

   task automatic xch(input logic [13:0] code, input logic [31:0] data, input logic b15,
                      input int lg, input logic res, input logic [31:0] expd, input logic cd);
      logic [15:0] r;
      logic [31:0] d;
      int          lat;
      cm.exchange(code, data, b15, lg, r, d, lat);
      if (cm.hung) begin
         failures++;
         tally_and_finish();
      end
      `CHK("latency", 2, lat)
      `CHK("response", {res, 1'b1, code}, r)
      if (cd) `CHK("resp data", expd, d)
   endtask : xch

   task automatic frame(input logic [4:0] a, input logic [15:0] w);
      @(posedge clk);
      #1 fv = 1'b1;
      faddr = a;
      fword = w;
      @(posedge clk);
      #1 fv = 1'b0;
      faddr = ~a;
      fword = ~w;
   endtask : frame

   // ======================================================================
   // scenarios
   initial begin
      #200000;
      failures++;
      tally_and_finish();
   end

   initial begin
      rst(32'hFFFF_FFFF, 16'h0000);
      `CHK("rsp reset", 16'h0000, rsp_w)
      xch(`RD_GROUP_ADDR, 0, 0, 1, 0, `NO_GROUP, 1);
      xch(`RD_INIT_GROUP, 0, 0, 1, 0, `NO_GROUP, 1);
      $display("test power-up defaults done");
      frame(5'h05, 16'hA5C3);
      `CHK("own frame", 16'hA5C3, in_w)
      `CHK("fields", 16'hA5C3, {rpos, fpos, rjog, fjog, sequential_start, dsel, aclr, free_o, stop, home, start, op_sel})
      frame(5'h03, 16'h0000);
      `CHK("foreign frame", 16'hA5C3, in_w)
      $display("test individual frames done");
      xch(`WR_GROUP_ADDR, 3, 1, 4, 0, `NO_GROUP, 1);
      xch(`WR_GROUP_MASK, 32'h00F0, 0, 1, 0, 0, 1);
      xch(`RD_GROUP_ADDR, 0, 0, 1, 0, 3, 1);
      frame(5'h03, 16'hFFFF);
      `CHK("group frame", 16'hA5F3, in_w)
      frame(5'h05, 16'h0000);
      `CHK("own masked", 16'h00F0, in_w)
      frame(5'h07, 16'hFFFF);
      `CHK("other group", 16'h00F0, in_w)
      $display("test grouping done");
      xch(`WR_GROUP_ADDR, 16, 0, 1, 1, 3, 1);
      xch(`RD_GROUP_ADDR, 0, 0, 1, 0, 3, 1);
      xch(14'h0123, 0, 0, 1, 1, 0, 0);
      xch(`WR_INIT_GROUP, 20, 0, 1, 0, `NO_GROUP, 1);
      `CHK("nv pulses", 1, nv_cnt)
      `CHK("nv data", 32'h0000_0014, nv_seen)
      xch(`RD_GROUP_ADDR, 0, 0, 1, 0, 3, 1);
      $display("test refusals and saved value done");
      frame(5'h05, 16'h000B);
      st = 12'hA5C;
      repeat (2) @(posedge clk);
      #1 `CHK("out word", 16'hA5CB, out_w)
      mode8 = 1'b1;
      frame(5'h05, 16'hFFFF);
      `CHK("in word 8", 16'h00FF, in_w)
      @(posedge clk);
      #1 `CHK("out word 8", 16'h00CF, out_w)
      mode8 = 1'b0;
      $display("test output word done");
      rst(32'h0000_0014, 16'h0003);
      xch(`RD_GROUP_ADDR, 0, 0, 1, 0, 32'h0000_0014, 1);
      xch(`RD_INIT_GROUP, 0, 0, 1, 0, 32'h0000_0014, 1);
      xch(`RD_GROUP_MASK, 0, 0, 1, 0, 32'h0000_0003, 1);
      $display("test saved power-up done");
      tally_and_finish();
   end
endmodule : remote_io_register_link_tb
